// ===== pkg/rf_timer_consts.svh
// Offsets, field positions, reset values and rates of the timer section
`ifndef RF_TIMER_CONSTS_SVH
`define RF_TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RUN_CTRL_IDX      8'h0E
`define ZERO_CFG_IDX      8'h0F
`define RELOAD_HIGH_IDX   8'h10
`define RELOAD_LOW_IDX    8'h11
`define IRQ_STATUS_IDX    8'h20
`define IRQ_MASK_IDX      8'h21

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RUN_LSB           4
`define CFG_HALT_BIT      7
`define CFG_MODE_MSB      5
`define CFG_MODE_LSB      4
`define CFG_RESTART_BIT   3
`define CFG_CLK_MSB       1
`define CFG_CLK_LSB       0
`define CFG_VALID_MASK    8'hBB

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RST           8'h00
`define RELOAD_RST        8'h00
`define COUNT_RST         16'h0000
`define IRQ_STATUS_RST    1'b0
`define IRQ_MASK_RST      1'b0

// ----------------------------------------------------------------
// Rates in kHz and the slow tick divide count; the fast tick is a fractional divide of pclk
// ----------------------------------------------------------------
`define PCLK_KHZ          18'h30D40
`define FAST_TICK_KHZ     18'h034F8
`define SLOW_TICK_DIV     6'h3F

`endif

// ===== pkg/rf_timer_pkg.sv
// Types shared by the timer section
package rf_timer_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_COUNT
	} timer_state_t;

	typedef enum logic [1:0] {
		START_NONE,
		START_TX_END,
		START_TRIM_HOLD,
		START_TRIM_WRAP
	} start_mode_t;

	typedef enum logic [1:0] {
		CLK_FAST,
		CLK_SLOW,
		CLK_TIMER_TWO,
		CLK_TIMER_ONE
	} clock_sel_t;

endpackage : rf_timer_pkg

// ===== testbench/rf_timer_ctrl_sva.sv
// Concurrent checks on the timer section ports
`timescale 1ns/1ps
`include "rf_timer_consts.svh"
module rf_timer_ctrl_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [9:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tx_end_pulse,
	input wire logic        rx_first_bits_pulse,
	input wire logic        lfo_clock_pin,
	input wire logic [3:1]  sibling_underflow,
	input wire logic [3:1]  sibling_halted,
	input wire logic [3:0]  run_state,
	input wire logic        timer_zero_underflow,
	input wire logic        irq
);
	logic acc;
	logic mapped;
	logic wr_run;
	logic mask_ff;
	assign acc    = psel && penable;
	assign wr_run = acc && pwrite && paddr[9:2] == `RUN_CTRL_IDX;
	assign mapped = paddr[1:0] == 2'b00 && paddr[9:2] inside {`RUN_CTRL_IDX, `ZERO_CFG_IDX,
		`RELOAD_HIGH_IDX, `RELOAD_LOW_IDX, `IRQ_STATUS_IDX, `IRQ_MASK_IDX};
	// Mask is not a port, so shadow it from bus writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_ff <= 1'b0;
		else if (acc && pwrite && paddr[9:2] == `IRQ_MASK_IDX)
			mask_ff <= pwdata[0];
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_zero_on;
		wr_run && pwdata[0] && pwdata[4];
	endsequence
	sequence s_zero_off;
		wr_run && pwdata[0] && !pwdata[4];
	endsequence
	a_unmapped_err: assert property (acc |-> pslverr == !mapped)
		else $error("slave error does not match address map");
	a_mask_wo: assert property (acc && !pwrite && paddr[9:2] == `RUN_CTRL_IDX |-> prdata[3:0] == 4'h0)
		else $error("mask bits read back nonzero");
	a_run_mask: assert property (wr_run |=> ((run_state[3:1] ^ $past(pwdata[7:5])) & $past(pwdata[3:1])) == 3'b000)
		else $error("masked running bit not taken");
	a_run_keep: assert property (wr_run && sibling_halted == 3'b000 |=>
		((run_state[3:1] ^ $past(run_state[3:1])) & ~$past(pwdata[3:1])) == 3'b000)
		else $error("unmasked running bit changed");
	a_zero_start: assert property (s_zero_on |=> run_state[0])
		else $error("timer zero not started");
	a_zero_stop: assert property (s_zero_off |=> !run_state[0] ##1 (!run_state[0] || $past(tx_end_pulse)))
		else $error("timer zero not stopped");
	a_halt_clears: assert property (!wr_run && sibling_halted != 3'b000 |=>
		(run_state[3:1] & $past(sibling_halted)) == 3'b000)
		else $error("halted sibling still shown running");
	a_uf_needs_run: assert property (timer_zero_underflow |-> $past(run_state[0]) || $past(run_state[0], 2))
		else $error("underflow while idle");
	a_irq_on_uf: assert property (timer_zero_underflow && mask_ff |-> irq)
		else $error("underflow did not raise irq");
	a_irq_masked: assert property (acc && pwrite && paddr[9:2] == `IRQ_MASK_IDX && !pwdata[0] |=> !irq)
		else $error("irq high while masked");
endmodule : rf_timer_ctrl_sva

bind rf_frontend_timer_control rf_timer_ctrl_sva chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_end_pulse(tx_end_pulse), .rx_first_bits_pulse(rx_first_bits_pulse),
	.lfo_clock_pin(lfo_clock_pin), .sibling_underflow(sibling_underflow),
	.sibling_halted(sibling_halted), .run_state(run_state),
	.timer_zero_underflow(timer_zero_underflow), .irq(irq));

// ===== testbench/tb.sv
// Self-checking bench for the timer section
`timescale 1ns/1ps
`include "rf_timer_consts.svh"
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic        tx_end_pulse, rx_first_bits_pulse, lfo_clock_pin, timer_zero_underflow, irq;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:1]  sibling_underflow, sibling_halted;
	logic [3:0]  run_state;
	int          fails, checks, ufs, u;

	rf_frontend_timer_control uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_end_pulse(tx_end_pulse), .rx_first_bits_pulse(rx_first_bits_pulse),
		.lfo_clock_pin(lfo_clock_pin), .sibling_underflow(sibling_underflow),
		.sibling_halted(sibling_halted), .run_state(run_state),
		.timer_zero_underflow(timer_zero_underflow), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Whole run is near 6600 cycles; the 40000-cycle limit leaves ample margin
	initial begin
		#200000;
		fails++;
		test_done();
	end
	always @(posedge pclk) begin
		if (timer_zero_underflow === 1'b1)
			ufs++;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n == 16) begin
			fails++;
			test_done();
		end
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so the next setup never re-drives psel in this step
		@(posedge pclk);
	endtask : xfer
	task automatic tick(input logic [3:1] v, input int n);
		repeat (n) begin
			sibling_underflow <= v;
			@(posedge pclk);
			sibling_underflow <= 3'b000;
			@(posedge pclk);
		end
		idle(1);
	endtask : tick
	task automatic pulse_in(input logic tx);
		if (tx)
			tx_end_pulse <= 1'b1;
		else
			rx_first_bits_pulse <= 1'b1;
		@(posedge pclk);
		tx_end_pulse <= 1'b0;
		rx_first_bits_pulse <= 1'b0;
		idle(2);
	endtask : pulse_in
	task automatic lfo_edge();
		lfo_clock_pin <= 1'b1;
		idle(5);
		lfo_clock_pin <= 1'b0;
		idle(5);
	endtask : lfo_edge
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [7:0] idxs [6] = '{`RUN_CTRL_IDX, `ZERO_CFG_IDX, `RELOAD_HIGH_IDX, `RELOAD_LOW_IDX,
			`IRQ_STATUS_IDX, `IRQ_MASK_IDX};
		foreach (idxs[i]) begin
			xfer(1'b0, idxs[i], 8'h00);
			chk(rdat, 32'h00000000);
		end
		xfer(1'b0, 8'h3F, 8'h00);
		chk(32'(serr), 32'h00000001);
		chk(rdat, 32'h00000000);
		xfer(1'b1, `ZERO_CFG_IDX, 8'hFF);
		xfer(1'b0, `ZERO_CFG_IDX, 8'h00);
		chk(rdat, 32'(`CFG_VALID_MASK));
		xfer(1'b1, `RELOAD_HIGH_IDX, 8'h5A);
		xfer(1'b0, `RELOAD_HIGH_IDX, 8'h00);
		chk(rdat, 32'h0000005A);
		xfer(1'b1, `RELOAD_HIGH_IDX, 8'h00);
		xfer(1'b1, `RUN_CTRL_IDX, 8'hF0);
		idle(1);
		chk(32'(run_state), 32'h00000000);
	endtask : t_regs
	task automatic t_count();
		xfer(1'b1, `RELOAD_LOW_IDX, 8'h02);
		xfer(1'b1, `ZERO_CFG_IDX, 8'h02);
		xfer(1'b1, `IRQ_MASK_IDX, 8'h01);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h11);
		xfer(1'b1, `RELOAD_LOW_IDX, 8'h05);
		u = ufs;
		tick(3'b101, 3);
		tick(3'b010, 2);
		chk(ufs, u);
		chk(32'(run_state[0]), 32'h00000001);
		tick(3'b010, 1);
		chk(ufs, u + 1);
		chk(32'(run_state[0]), 32'h00000000);
		chk(32'(irq), 32'h00000001);
		xfer(1'b0, `IRQ_STATUS_IDX, 8'h00);
		chk(rdat, 32'h00000001);
		idle(1);
		chk(32'(irq), 32'h00000000);
	endtask : t_count
	task automatic t_restart();
		xfer(1'b1, `IRQ_MASK_IDX, 8'h00);
		xfer(1'b1, `ZERO_CFG_IDX, 8'h0B);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h11);
		u = ufs;
		tick(3'b001, 5);
		chk(ufs, u);
		tick(3'b001, 1);
		chk(ufs, u + 1);
		chk(32'(run_state[0]), 32'h00000001);
		chk(32'(irq), 32'h00000000);
		tick(3'b001, 6);
		chk(ufs, u + 2);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h01);
		xfer(1'b0, `IRQ_STATUS_IDX, 8'h00);
		chk(rdat, 32'h00000001);
		chk(32'(run_state[0]), 32'h00000000);
	endtask : t_restart
	task automatic t_auto();
		xfer(1'b1, `ZERO_CFG_IDX, 8'h92);
		pulse_in(1'b1);
		chk(32'(run_state[0]), 32'h00000001);
		pulse_in(1'b0);
		chk(32'(run_state[0]), 32'h00000000);
		xfer(1'b1, `ZERO_CFG_IDX, 8'h02);
		pulse_in(1'b1);
		chk(32'(run_state[0]), 32'h00000000);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h11);
		pulse_in(1'b0);
		chk(32'(run_state[0]), 32'h00000001);
		xfer(1'b1, `ZERO_CFG_IDX, 8'hA2);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h11);
		u = ufs;
		lfo_edge();
		pulse_in(1'b0);
		chk(32'(run_state[0]), 32'h00000001);
		tick(3'b010, 8);
		chk(ufs, u);
		lfo_edge();
		chk(32'(run_state[0]), 32'h00000000);
		xfer(1'b1, `ZERO_CFG_IDX, 8'h32);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h11);
		lfo_edge();
		tick(3'b010, 6);
		chk(ufs, u + 1);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h01);
	endtask : t_auto
	task automatic t_rate(input logic [7:0] cfg, input logic [7:0] rh, input logic [7:0] rl,
		input int early, input int late);
		xfer(1'b1, `RELOAD_HIGH_IDX, rh);
		xfer(1'b1, `RELOAD_LOW_IDX, rl);
		xfer(1'b1, `ZERO_CFG_IDX, cfg);
		u = ufs;
		xfer(1'b1, `RUN_CTRL_IDX, 8'h11);
		idle(early);
		chk(ufs, u);
		idle(late - early);
		chk(ufs, u + 1);
	endtask : t_rate
	task automatic t_sib();
		xfer(1'b1, `RUN_CTRL_IDX, 8'hEE);
		xfer(1'b0, `RUN_CTRL_IDX, 8'h00);
		chk(rdat, 32'h000000E0);
		sibling_halted <= 3'b010;
		@(posedge pclk);
		sibling_halted <= 3'b000;
		idle(1);
		chk(32'(run_state), 32'h0000000A);
		xfer(1'b1, `RUN_CTRL_IDX, 8'h0E);
		idle(1);
		chk(32'(run_state), 32'h00000000);
	endtask : t_sib

	initial begin
		{presetn, psel, penable, pwrite, tx_end_pulse, rx_first_bits_pulse, lfo_clock_pin} = '0;
		{paddr, pwdata, sibling_underflow, sibling_halted} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_count();
		t_restart();
		t_auto();
		t_rate(8'h00, 8'h00, 8'h10, 200, 300);
		t_rate(8'h00, 8'h01, 8'h00, 3600, 4000);
		t_rate(8'h01, 8'h00, 8'h01, 800, 2000);
		t_sib();
		test_done();
	end
endmodule : tb

// ===== verilog/rf_frontend_timer_control.sv
// Timer section run control and timer zero, reached over APB
`timescale 1ns/1ps
`include "rf_timer_consts.svh"

// Notes on behaviour
// - Writes change running bits only where mask set
// - Upper bits show live state, start/stop timers
// - Lower mask bits write-only, enable bit above
// - Halt-on-receive stops after first four bits
// - Halt-on-receive ignored in trimming modes
// - Mode 00 manual, 01 starts at TX end
// - Modes 10/11 trim oscillator, edge start/stop
// - Auto-restart reloads and continues at zero, except mode 10
// - Without auto-restart modes 00/01/11 stop at zero
// - Each underflow sets the underflow flag
// - Clock select 00 fast, 01 slow tick
// - Clock select 10/11 cascade sibling underflows
// - Start event loads sixteen-bit reload value
// - Reload writes act at next start or auto-restart reload
module rf_frontend_timer_control (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [9:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tx_end_pulse,
	input  wire logic        rx_first_bits_pulse,
	input  wire logic        lfo_clock_pin,
	input  wire logic [3:1]  sibling_underflow,
	input  wire logic [3:1]  sibling_halted,
	output logic      [3:0]  run_state,
	output logic             timer_zero_underflow,
	output logic             irq
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
		reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
	endfunction : reg_hit

	logic                        setup_phase;
	logic                        access_phase;
	logic                        wr_en;
	logic                        rd_en;
	logic                        mapped;
	logic                        run_ctrl_wr;

	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_en        = access_phase & pwrite;
	assign rd_en        = access_phase & ~pwrite;
	assign mapped       = reg_hit(paddr, `RUN_CTRL_IDX) | reg_hit(paddr, `ZERO_CFG_IDX)
	                    | reg_hit(paddr, `RELOAD_HIGH_IDX) | reg_hit(paddr, `RELOAD_LOW_IDX)
	                    | reg_hit(paddr, `IRQ_STATUS_IDX) | reg_hit(paddr, `IRQ_MASK_IDX);
	assign run_ctrl_wr  = wr_en & reg_hit(paddr, `RUN_CTRL_IDX);

	// Zero-wait slave: read data was captured in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = access_phase & ~mapped;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]                  cfg_ff;
	logic [7:0]                  reload_high_byte_ff;
	logic [7:0]                  reload_low_byte_ff;
	logic                        irq_status_ff;
	logic                        irq_mask_ff;
	logic [31:0]                 prdata_ff;
	wire logic [3:1]             sibling_run;
	rf_timer_pkg::timer_state_t  state_ff;
	logic [15:0]                 count_ff;
	logic                        underflow_ff;

	// Field views
	logic                        halt_on_first_rx_bits;
	rf_timer_pkg::start_mode_t   start_mode_select;
	logic                        reload_on_zero;
	rf_timer_pkg::clock_sel_t    input_clock_select;
	logic [15:0]                 reload_value;
	logic                        trim_mode;

	assign halt_on_first_rx_bits = cfg_ff[`CFG_HALT_BIT];
	assign start_mode_select     = rf_timer_pkg::start_mode_t'(cfg_ff[`CFG_MODE_MSB:`CFG_MODE_LSB]);
	assign reload_on_zero        = cfg_ff[`CFG_RESTART_BIT];
	assign input_clock_select    = rf_timer_pkg::clock_sel_t'(cfg_ff[`CFG_CLK_MSB:`CFG_CLK_LSB]);
	assign reload_value          = {reload_high_byte_ff, reload_low_byte_ff};
	assign trim_mode             = start_mode_select[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= `CFG_RST;
		end else if (wr_en && reg_hit(paddr, `ZERO_CFG_IDX)) begin
			cfg_ff <= pwdata[7:0] & `CFG_VALID_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_high_byte_ff <= `RELOAD_RST;
			reload_low_byte_ff  <= `RELOAD_RST;
		end else begin
			if (wr_en && reg_hit(paddr, `RELOAD_HIGH_IDX)) begin
				reload_high_byte_ff <= pwdata[7:0];
			end
			if (wr_en && reg_hit(paddr, `RELOAD_LOW_IDX)) begin
				reload_low_byte_ff <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= `IRQ_MASK_RST;
		end else if (wr_en && reg_hit(paddr, `IRQ_MASK_IDX)) begin
			irq_mask_ff <= pwdata[0];
		end
	end

	// ----------------------------------------------------------------
	// Tick generation
	// ----------------------------------------------------------------
	// Fractional accumulator: average rate exact, jitter one pclk
	logic [17:0] frac_acc_ff;
	logic [17:0] frac_sum;
	logic        fast_tick_ff;
	logic [5:0]  slow_div_ff;
	logic        slow_tick_ff;

	assign frac_sum = frac_acc_ff + `FAST_TICK_KHZ;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frac_acc_ff  <= 18'h00000;
			fast_tick_ff <= 1'b0;
		end else if (frac_sum >= `PCLK_KHZ) begin
			frac_acc_ff  <= frac_sum - `PCLK_KHZ;
			fast_tick_ff <= 1'b1;
		end else begin
			frac_acc_ff  <= frac_sum;
			fast_tick_ff <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_div_ff  <= 6'h00;
			slow_tick_ff <= 1'b0;
		end else begin
			slow_tick_ff <= 1'b0;
			if (fast_tick_ff) begin
				slow_div_ff <= slow_div_ff + 6'h01;
				if (slow_div_ff == `SLOW_TICK_DIV) begin
					slow_tick_ff <= 1'b1;
				end
			end
		end
	end

	logic tick;

	always_comb begin
		case (input_clock_select)
			rf_timer_pkg::CLK_FAST:      tick = fast_tick_ff;
			rf_timer_pkg::CLK_SLOW:      tick = slow_tick_ff;
			rf_timer_pkg::CLK_TIMER_TWO: tick = sibling_underflow[2];
			rf_timer_pkg::CLK_TIMER_ONE: tick = sibling_underflow[1];
			default:                     tick = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Oscillator pin synchroniser and edge detect
	// ----------------------------------------------------------------
	logic lfo_meta_ff;
	logic lfo_sync_ff;
	logic lfo_prev_ff;
	logic lfo_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfo_meta_ff <= 1'b0;
			lfo_sync_ff <= 1'b0;
			lfo_prev_ff <= 1'b0;
		end else begin
			lfo_meta_ff <= lfo_clock_pin;
			lfo_sync_ff <= lfo_meta_ff;
			lfo_prev_ff <= lfo_sync_ff;
		end
	end

	assign lfo_rise = lfo_sync_ff & ~lfo_prev_ff;

	// ----------------------------------------------------------------
	// Timer zero control
	// ----------------------------------------------------------------
	logic sw_start;
	logic sw_stop;
	logic trim_stop;
	logic rx_halt;
	logic auto_start;
	logic underflow_now;

	assign sw_start   = run_ctrl_wr & pwdata[0] & pwdata[`RUN_LSB];
	assign sw_stop    = run_ctrl_wr & pwdata[0] & ~pwdata[`RUN_LSB];
	assign trim_stop  = trim_mode & lfo_rise;
	assign rx_halt    = halt_on_first_rx_bits & ~trim_mode & rx_first_bits_pulse;
	assign auto_start = (start_mode_select == rf_timer_pkg::START_TX_END) & tx_end_pulse;

	// Underflow is a tick at zero while counting, except in mode 10 or when a start, stop or halt comes in the same cycle
	assign underflow_now = (state_ff == rf_timer_pkg::ST_COUNT) & tick & (count_ff == 16'h0000)
	                     & (start_mode_select != rf_timer_pkg::START_TRIM_HOLD)
	                     & ~sw_start & ~sw_stop & ~trim_stop & ~rx_halt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= rf_timer_pkg::ST_IDLE;
			count_ff <= `COUNT_RST;
		end else if (sw_stop) begin
			state_ff <= rf_timer_pkg::ST_IDLE;
		end else if (sw_start) begin
			// Trimming waits for an oscillator edge
			if (trim_mode) begin
				state_ff <= rf_timer_pkg::ST_ARMED;
			end else begin
				state_ff <= rf_timer_pkg::ST_COUNT;
				count_ff <= reload_value;
			end
		end else begin
			case (state_ff)
				rf_timer_pkg::ST_IDLE: begin
					if (auto_start) begin
						state_ff <= rf_timer_pkg::ST_COUNT;
						count_ff <= reload_value;
					end
				end
				rf_timer_pkg::ST_ARMED: begin
					if (!trim_mode) begin
						state_ff <= rf_timer_pkg::ST_IDLE;
					end else if (lfo_rise) begin
						state_ff <= rf_timer_pkg::ST_COUNT;
						count_ff <= reload_value;
					end
				end
				rf_timer_pkg::ST_COUNT: begin
					if (trim_stop) begin
						// Next edge ends the trim count
						state_ff <= rf_timer_pkg::ST_IDLE;
					end else if (rx_halt) begin
						state_ff <= rf_timer_pkg::ST_IDLE;
					end else if (tick) begin
						if (count_ff != 16'h0000) begin
							count_ff <= count_ff - 16'h0001;
						end else if (start_mode_select == rf_timer_pkg::START_TRIM_HOLD) begin
							// Trim without underflow holds at zero
							count_ff <= 16'h0000;
						end else if (reload_on_zero) begin
							count_ff <= reload_value;
						end else begin
							state_ff <= rf_timer_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_ff <= rf_timer_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			underflow_ff <= 1'b0;
		end else begin
			underflow_ff <= underflow_now;
		end
	end

	assign timer_zero_underflow = underflow_ff;

	// ----------------------------------------------------------------
	// Sibling timer running bits
	// ----------------------------------------------------------------
	// Software write wins over a sibling's own halt in the same cycle
	genvar gi;
	generate
		for (gi = 1; gi < 4; gi++) begin : g_sibling
			// One flop per process keeps each bit single-driven
			logic run_bit_ff;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					run_bit_ff <= 1'b0;
				end else if (run_ctrl_wr && pwdata[gi]) begin
					run_bit_ff <= pwdata[gi+`RUN_LSB];
				end else if (sibling_halted[gi]) begin
					run_bit_ff <= 1'b0;
				end
			end

			assign sibling_run[gi] = run_bit_ff;
		end
	endgenerate

	assign run_state = {sibling_run, state_ff != rf_timer_pkg::ST_IDLE};

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	logic status_read;

	assign status_read = rd_en & reg_hit(paddr, `IRQ_STATUS_IDX);

	// Set wins; a read clears only what it returned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_ff <= `IRQ_STATUS_RST;
		end else begin
			irq_status_ff <= (irq_status_ff & ~(status_read & prdata_ff[0])) | underflow_now;
		end
	end

	assign irq = irq_status_ff & irq_mask_ff;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (reg_hit(paddr, `RUN_CTRL_IDX)) begin
			rd_mux[7:0] = {run_state, 4'h0};
		end
		if (reg_hit(paddr, `ZERO_CFG_IDX)) begin
			rd_mux[7:0] = cfg_ff;
		end
		if (reg_hit(paddr, `RELOAD_HIGH_IDX)) begin
			rd_mux[7:0] = reload_high_byte_ff;
		end
		if (reg_hit(paddr, `RELOAD_LOW_IDX)) begin
			rd_mux[7:0] = reload_low_byte_ff;
		end
		if (reg_hit(paddr, `IRQ_STATUS_IDX)) begin
			rd_mux[0] = irq_status_ff;
		end
		if (reg_hit(paddr, `IRQ_MASK_IDX)) begin
			rd_mux[0] = irq_mask_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata_ff <= rd_mux;
		end
	end

	assign prdata = prdata_ff;

endmodule : rf_frontend_timer_control
